/* logic/pcm_clock_ctrl.sv */
/*
 * PLL clock control: multiplier, halve select, power-down, lock timing,
 * lost-oscillator detection and a classic Wishbone register slave.
 * Assumes oscillator pins are asynchronous and no faster than core_clk / 4.
 */
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
module pcm_clock_ctrl #(
	parameter int LOCK_CYCLES = pcm_pkg::LOCK_OSC_CYCLES,
	parameter int MISS_LIMIT  = pcm_pkg::MISS_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [17:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  protWriteUnlock,
	input  wire logic                  crystalInPin,
	input  wire logic                  externalClockPin,
	output pcm_pkg::pcm_clk_cfg_s      clkCfg,
	output logic                       missingClockReset,
	output logic                       irq
);
	import pcm_pkg::*;

	localparam int CW = $clog2(LOCK_CYCLES + 1);
	localparam int MW = $clog2(MISS_LIMIT + 1);
	localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CYCLES - 1);
	localparam logic [MW-1:0] MISS_LAST = MW'(MISS_LIMIT - 1);

	// ********************************************************
	// oscillator input sampling
	// ********************************************************
	logic [2:0] oscSyncQ;
	logic       oscLvlQ;
	// unused pin is tied low, so either source alone drives the oscillator
	wire        oscRaw  = crystalInPin | externalClockPin;
	wire        oscAgree = oscSyncQ[1] == oscSyncQ[2];
	wire        oscEdge = oscAgree & oscSyncQ[2] & ~oscLvlQ;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			oscSyncQ <= 3'h0;
			oscLvlQ  <= 1'b0;
		end else begin
			oscSyncQ <= {oscSyncQ[1:0], oscRaw};
			if (oscAgree) begin
				oscLvlQ <= oscSyncQ[2];
			end
		end
	end

	// ********************************************************
	// bus decode
	// ********************************************************
	logic        ackQ;
	logic [3:0]  multQ;
	logic        lockQ;
	logic        halveQ;
	logic        pdownQ;
	logic        missQ;
	logic        seenQ;
	logic        limpQ;
	logic [EVT_W-1:0] statQ;
	logic [EVT_W-1:0] maskQ;
	logic [15:0] plainQ [PLAIN_REGS];
	logic [CW-1:0] lockCntQ;
	logic [MW-1:0] missCntQ;

	wire [15:0] idx      = wb_adr_i[17:2];
	wire        acc      = wb_cyc_i & wb_stb_i & ~ackQ;
	wire        wr       = acc & wb_we_i;
	wire        wrOk     = wr & protWriteUnlock;
	wire        hitMult  = idx == IDX_MULT;
	wire        hitState = idx == IDX_PLL_STATE;
	wire        hitPin   = idx == IDX_CLK_PIN;
	wire        hitStat  = idx == IDX_IRQ_STAT;
	wire        hitMask  = idx == IDX_IRQ_MASK;
	wire [3:0]  multIn   = wb_dat_i[3:0];
	// reserved codes are refused outright, the old ratio stays
	wire        multLegal = multIn <= MULT_MAX;
	wire        multWr   = wrOk & hitMult & wb_sel_i[0] & multLegal;
	wire        stateWr  = wrOk & hitState & wb_sel_i[0];
	wire        statWr   = wr & hitStat & wb_sel_i[0];
	wire        maskWr   = wr & hitMask & wb_sel_i[0];

	// ********************************************************
	// lock timing
	// ********************************************************
	wire pllOn   = ~pdownQ;
	wire lockEvt = pllOn & ~multWr & ~lockQ & oscEdge
		& (lockCntQ == LOCK_LAST);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lockCntQ <= '0;
			lockQ    <= 1'b0;
		end else if (multWr || !pllOn) begin
			lockCntQ <= '0;
			lockQ    <= 1'b0;
		end else if (lockEvt) begin
			lockQ <= 1'b1;
		end else if (oscEdge && !lockQ) begin
			lockCntQ <= lockCntQ + CW'(1);
		end
	end

	// ********************************************************
	// lost oscillator
	// ********************************************************
	wire missEvt = seenQ & ~limpQ & ~oscEdge & (missCntQ == MISS_LAST);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			missCntQ <= '0;
			seenQ    <= 1'b0;
			limpQ    <= 1'b0;
		end else if (oscEdge) begin
			missCntQ <= '0;
			seenQ    <= 1'b1;
			limpQ    <= 1'b0;
		end else if (missEvt) begin
			limpQ <= 1'b1;
		end else if (seenQ && !limpQ) begin
			missCntQ <= missCntQ + MW'(1);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			missingClockReset <= 1'b0;
		end else begin
			missingClockReset <= missEvt;
		end
	end

	// ********************************************************
	// control registers
	// ********************************************************
	// a new missing event outranks a write-one clear
	wire missD = missEvt | (missQ & ~(stateWr & wb_dat_i[STS_MISS]));
	wire [EVT_W-1:0] evt;
	assign evt[EVT_LOCK] = lockEvt;
	assign evt[EVT_MISS] = missEvt;
	wire [EVT_W-1:0] statD =
		evt | (statQ & ~(statWr ? wb_dat_i[EVT_W-1:0] : '0));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			multQ  <= MULT_RST;
			halveQ <= 1'b0;
			pdownQ <= 1'b0;
			missQ  <= 1'b0;
			statQ  <= '0;
			maskQ  <= '0;
		end else begin
			if (multWr) begin
				multQ <= multIn;
			end
			if (stateWr) begin
				halveQ <= wb_dat_i[STS_HALVE];
				pdownQ <= wb_dat_i[STS_PDOWN];
			end
			missQ <= missD;
			statQ <= statD;
			if (maskWr) begin
				maskQ <= wb_dat_i[EVT_W-1:0];
			end
		end
	end

	// peripheral prescaler, gate and low-power words are plain storage
	logic [15:0] plainIdx [PLAIN_REGS];
	assign plainIdx[0] = IDX_FAST_PRE;
	assign plainIdx[1] = IDX_SLOW_PRE;
	assign plainIdx[2] = IDX_GATE0;
	assign plainIdx[3] = IDX_GATE1;
	assign plainIdx[4] = IDX_LPM;
	logic [PLAIN_REGS-1:0] plainHit;

	genvar g;
	generate
		for (g = 0; g < PLAIN_REGS; g++) begin : gPlain
			assign plainHit[g] = idx == plainIdx[g];
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					plainQ[g] <= PLAIN_RST;
				end else if (wrOk && plainHit[g]) begin
					if (wb_sel_i[0]) plainQ[g][7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) plainQ[g][15:8] <= wb_dat_i[15:8];
				end
			end
		end
	endgenerate

	// ********************************************************
	// clock selection
	// ********************************************************
	// power-down assumes the multiplier was zeroed first
	wire enableOk = pllOn & lockQ & (multQ != MULT_RST);
	pcm_clk_cfg_s cfgD;
	always_comb begin
		cfgD.divBy2 = ~halveQ;
		cfgD.mult   = MULT_ONE;
		if (limpQ) begin
			cfgD.mode = MODE_LIMP;
		end else if (!pllOn) begin
			cfgD.mode = MODE_OFF;
		end else if (enableOk) begin
			cfgD.mode = MODE_ENABLE;
			cfgD.mult = multQ;
		end else begin
			cfgD.mode = MODE_BYPASS;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clkCfg <= '{mode: MODE_BYPASS, mult: MULT_ONE, divBy2: 1'b1};
		end else begin
			clkCfg <= cfgD;
		end
	end

	// ********************************************************
	// read path and answer
	// ********************************************************
	logic [15:0] stateRd;
	logic [15:0] pinRd;
	logic [15:0] plainRd;
	always_comb begin
		stateRd            = 16'h0000;
		stateRd[STS_LOCK]  = lockQ;
		stateRd[STS_HALVE] = halveQ;
		stateRd[STS_PDOWN] = pdownQ;
		stateRd[STS_MISS]  = missQ;
		pinRd              = 16'h0000;
		pinRd[PIN_SEEN]    = seenQ;
		pinRd[PIN_LIMP]    = limpQ;
		plainRd            = 16'h0000;
		for (int i = 0; i < PLAIN_REGS; i++) begin
			if (plainHit[i]) plainRd = plainQ[i];
		end
	end

	// unmapped words read zero and swallow writes
	wire [15:0] rdData =
		hitMult  ? {12'h000, multQ} :
		hitState ? stateRd :
		hitPin   ? pinRd :
		hitStat  ? {14'h0000, statQ} :
		hitMask  ? {14'h0000, maskQ} : plainRd;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackQ     <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ackQ <= acc;
			if (acc) begin
				wb_dat_o <= {16'h0000, rdData};
			end
		end
	end

	assign wb_ack_o = ackQ;
	assign irq      = |(statQ & maskQ);

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_write_forces_bypass: assert property (
		multWr |-> ##2 clkCfg.mode != MODE_ENABLE)
		else $error("multiplier write did not force bypass");
	a_reserved_refused: assert property (
		wr && hitMult && !multLegal |=> multQ == $past(multQ))
		else $error("reserved multiplier code was stored");
	a_locked_ratio: assert property (
		enableOk && !limpQ |=> clkCfg.mode == MODE_ENABLE
			&& clkCfg.mult == $past(multQ))
		else $error("locked ratio not applied");
	a_power_down_off: assert property (
		pdownQ && !limpQ |=> clkCfg.mode == MODE_OFF)
		else $error("power-down did not stop the PLL");
	a_halve_divider: assert property (
		1'b1 |=> clkCfg.divBy2 == !$past(halveQ))
		else $error("halve select not reflected");
	a_locked_guard: assert property (
		wr && !protWriteUnlock |=> $stable(multQ) && $stable(pdownQ)
			&& $stable(halveQ))
		else $error("protected register changed while locked");
	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_missing_clock: assert property (
		missEvt |=> missQ && missingClockReset
			&& statQ[EVT_MISS] ##1 clkCfg.mode == MODE_LIMP)
		else $error("lost oscillator not reported");
	a_lock_after_write: assert property (
		multWr |=> !lockQ ##1 !lockQ)
		else $error("lock flag survived a multiplier write");

	c_lock_reached: cover property (lockEvt);
	c_enable_mode: cover property (clkCfg.mode == MODE_ENABLE);
	c_clock_lost: cover property (missEvt);

endmodule : pcm_clock_ctrl

/* logic/pcm_pkg.sv */
/*
 * Constants, register map and carrier types of the PLL clock control block.
 * Assumes a 16-bit register word per index on a 32-bit classic Wishbone bus.
 */
// Functional notes
// - four-bit multiplier, zero bypass, above ten reserved
// - core clock is multiplied clock over n
// - halve select inserts divide-by-two before core; here setting it clears divBy2
// - multiplier write forces bypass until lock
// - reset gives bypass and zero multiplier
// - bypass routes oscillator around powered PLL
// - power-down bit disables PLL, input clock direct
// - locked nonzero multiplier clocks oscillator times n
// - oscillator taken from crystal or external pin
// - control registers writable only while unlocked; here IRQ status and mask writes ignore the lock
// - lost oscillator gives limp clock, reset, flag
package pcm_pkg;

	// ********************************************************
	// register indices (byte address is four times the index)
	// ********************************************************
	localparam logic [15:0] IDX_CLK_PIN   = 16'h7010;
	localparam logic [15:0] IDX_PLL_STATE = 16'h7011;
	localparam logic [15:0] IDX_FAST_PRE  = 16'h701A;
	localparam logic [15:0] IDX_SLOW_PRE  = 16'h701B;
	localparam logic [15:0] IDX_GATE0     = 16'h701C;
	localparam logic [15:0] IDX_GATE1     = 16'h701D;
	localparam logic [15:0] IDX_LPM       = 16'h701E;
	localparam logic [15:0] IDX_MULT      = 16'h7021;
	localparam logic [15:0] IDX_IRQ_STAT  = 16'h7030;
	localparam logic [15:0] IDX_IRQ_MASK  = 16'h7031;
	localparam int          PLAIN_REGS    = 5;

	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int          STS_LOCK   = 0;
	localparam int          STS_HALVE  = 1;
	localparam int          STS_PDOWN  = 2;
	localparam int          STS_MISS   = 3;
	localparam int          PIN_SEEN   = 0;
	localparam int          PIN_LIMP   = 1;
	localparam int          EVT_LOCK   = 0;
	localparam int          EVT_MISS   = 1;
	localparam int          EVT_W      = 2;
	localparam logic [3:0]  MULT_RST   = 4'h0;
	localparam logic [3:0]  MULT_MAX   = 4'hA;
	localparam logic [3:0]  MULT_ONE   = 4'h1;
	localparam logic [15:0] PLAIN_RST  = 16'h0000;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int LOCK_OSC_CYCLES = 131072;
	// oscillator silence that counts as a lost clock
	localparam int MISS_TIME_NS    = 1000;
	localparam int MISS_CYCLES     =
		(MISS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************************************
	// types
	// ********************************************************
	typedef enum logic [1:0] {
		MODE_BYPASS = 2'b00,
		MODE_ENABLE = 2'b01,
		MODE_OFF    = 2'b10,
		MODE_LIMP   = 2'b11
	} pcm_mode_e;

	typedef struct packed {
		pcm_mode_e  mode;
		logic [3:0] mult;
		logic       divBy2;
	} pcm_clk_cfg_s;

endpackage : pcm_pkg

/* tb/pcm_clock_ctrl_tb.sv */
/*
 * Self-checking bench of the PLL clock control block.
 * Assumes short lock and miss counts; oscillator period 40 ns.
 */
`timescale 1ns/1ns
module pcm_clock_ctrl_tb;
	import pcm_pkg::*;
	logic         core_clk, rst_n, cyc, stb, we, unlock, run, useExt;
	logic         ack, oscA, oscB, missRst, irq;
	logic [3:0]   sel;
	logic [17:0]  adr;
	logic [31:0]  datI, datO;
	logic [15:0]  rd;
	pcm_clk_cfg_s cfg;
	int           failures, n_tests, n;

	pcm_clock_ctrl #(.LOCK_CYCLES(8), .MISS_LIMIT(20)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
		.wb_ack_o(ack), .protWriteUnlock(unlock),
		.crystalInPin(oscA), .externalClockPin(oscB),
		.clkCfg(cfg), .missingClockReset(missRst), .irq(irq));
	pcm_osc_model osc_u (.run(run), .useExt(useExt), .crystalInPin(oscA),
		.externalClockPin(oscB));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic final_report;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	task automatic expire;
		chk(16'h0000, 16'h0001, "wait ran out");
		final_report();
	endtask : expire
	task automatic wb(input logic w, input logic [15:0] i, d);
		int k;
		k = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= {i, 2'b00};
		datI <= {16'h0000, d};
		do begin
			@(posedge core_clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		rd = datO[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 50) expire();
	endtask : wb
	task automatic rdc(input logic [15:0] i, e, input string m);
		wb(1'b0, i, 16'h0000);
		chk(rd, e, m);
	endtask : rdc
	task automatic wait_mode(input pcm_mode_e m);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (cfg.mode !== m && n < 400);
		if (n >= 400) expire();
	endtask : wait_mode
	task automatic mode_is(input pcm_mode_e m, input string s);
		repeat (2) @(negedge core_clk);
		chk(16'(cfg.mode), 16'(m), s);
	endtask : mode_is

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rdc(IDX_MULT, 16'h0000, "mult reset");
		rdc(IDX_PLL_STATE, 16'h0000, "state reset");
		chk(16'(cfg.mode), 16'(MODE_BYPASS), "mode reset");
		chk(16'(cfg.divBy2), 16'h0001, "halve reset");
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs;
		wb(1'b1, IDX_FAST_PRE, 16'hBEEF);
		rdc(IDX_FAST_PRE, 16'hBEEF, "plain rw");
		unlock <= 1'b0;
		wb(1'b1, IDX_FAST_PRE, 16'h1234);
		wb(1'b1, IDX_MULT, 16'h0003);
		wb(1'b1, IDX_PLL_STATE, 16'h0004);
		wb(1'b0, IDX_PLL_STATE, 16'h0000);
		chk(rd & 16'h0006, 16'h0000, "guarded state");
		rdc(IDX_FAST_PRE, 16'hBEEF, "guarded plain");
		rdc(IDX_MULT, 16'h0000, "guarded mult");
		unlock <= 1'b1;
		wb(1'b1, 16'h7012, 16'hFFFF);
		rdc(16'h7012, 16'h0000, "unmapped");
		$display("test registers done");
	endtask : t_regs
	task automatic t_lock;
		// halve select is still clear here
		wb(1'b1, IDX_MULT, 16'h0005);
		rdc(IDX_PLL_STATE, 16'h0000, "lock cleared");
		wait_mode(MODE_ENABLE);
		chk(16'(cfg.mult), 16'h0005, "ratio");
		rdc(IDX_PLL_STATE, 16'h0001, "locked");
		rdc(IDX_IRQ_STAT, 16'h0001, "lock event");
		chk(16'(irq), 16'h0000, "irq masked");
		wb(1'b1, IDX_IRQ_MASK, 16'h0001);
		repeat (2) @(negedge core_clk);
		chk(16'(irq), 16'h0001, "irq raised");
		wb(1'b1, IDX_IRQ_STAT, 16'h0001);
		repeat (2) @(negedge core_clk);
		chk(16'(irq), 16'h0000, "irq cleared");
		wb(1'b1, IDX_PLL_STATE, 16'h0002);
		repeat (2) @(negedge core_clk);
		chk(16'(cfg.divBy2), 16'h0000, "halve off");
		wb(1'b1, IDX_PLL_STATE, 16'h0000);
		wb(1'b1, IDX_MULT, 16'h000A);
		mode_is(MODE_BYPASS, "relock bypass");
		wait_mode(MODE_ENABLE);
		chk(16'(n >= 20), 16'h0001, "lock too early");
		chk(16'(cfg.mult), 16'h000A, "top ratio");
		wb(1'b1, IDX_MULT, 16'h000B);
		rdc(IDX_MULT, 16'h000A, "reserved code");
		@(negedge core_clk);
		chk(16'(cfg.mode), 16'(MODE_ENABLE), "lock kept");
		$display("test lock done");
	endtask : t_lock
	task automatic t_rerst;
		// ratio, mask and lock event are all set when this reset hits
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk(16'(cfg.mode), 16'(MODE_BYPASS), "reset bypass");
		chk(16'(cfg.mult), 16'(MULT_ONE), "reset ratio");
		chk(16'(irq), 16'h0000, "reset irq");
		rdc(IDX_MULT, 16'h0000, "reset mult");
		$display("test second reset done");
	endtask : t_rerst
	task automatic t_pdown;
		wb(1'b1, IDX_MULT, 16'h0000);
		mode_is(MODE_BYPASS, "zero is bypass");
		// this write leaves halve select clear, so power down stays halved
		wb(1'b1, IDX_PLL_STATE, 16'h0004);
		mode_is(MODE_OFF, "power down");
		chk(16'(cfg.divBy2), 16'h0001, "off halved");
		rdc(IDX_PLL_STATE, 16'h0004, "off no lock");
		wb(1'b1, IDX_PLL_STATE, 16'h0000);
		mode_is(MODE_BYPASS, "power up");
		$display("test power down done");
	endtask : t_pdown
	task automatic t_miss;
		wb(1'b1, IDX_IRQ_MASK, 16'h0002);
		run <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (missRst !== 1'b1 && n < 200);
		if (n >= 200) expire();
		wait_mode(MODE_LIMP);
		wb(1'b0, IDX_PLL_STATE, 16'h0000);
		chk(rd & 16'h0008, 16'h0008, "missing flag");
		chk(16'(irq), 16'h0001, "miss irq");
		rdc(IDX_CLK_PIN, 16'h0003, "limp status");
		useExt <= 1'b1;
		run <= 1'b1;
		wait_mode(MODE_BYPASS);
		rdc(IDX_CLK_PIN, 16'h0001, "external source");
		wb(1'b1, IDX_PLL_STATE, 16'h0008);
		wb(1'b0, IDX_PLL_STATE, 16'h0000);
		chk(rd & 16'h0008, 16'h0000, "missing flag clear");
		wb(1'b1, IDX_IRQ_STAT, 16'h0002);
		@(negedge core_clk);
		chk(16'(irq), 16'h0000, "miss irq cleared");
		$display("test lost clock done");
	endtask : t_miss

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		{rst_n, cyc, stb, we, sel, adr, datI} = '0;
		unlock = 1'b1;
		run = 1'b1;
		useExt = 1'b0;
		failures = 0;
		n_tests = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_lock();
		t_rerst();
		t_pdown();
		t_miss();
		final_report();
	end
endmodule : pcm_clock_ctrl_tb

/* tb/pcm_osc_model.sv */
/*
 * Oscillator source model for the clock control block.
 * Assumes the bench gates it with run and picks the pin with useExt;
 * half period is HALF_NS.
 */
`timescale 1ns/1ns
module pcm_osc_model #(
	parameter int HALF_NS = 20
) (
	input  wire logic run,
	input  wire logic useExt,
	output logic      crystalInPin,
	output logic      externalClockPin
);
	// a stopped source parks low, as a dead crystal does; unused pin tied low
	initial begin
		crystalInPin = 1'b0;
		externalClockPin = 1'b0;
		forever begin
			#HALF_NS;
			crystalInPin = (run && !useExt) ? ~crystalInPin : 1'b0;
			externalClockPin = (run && useExt) ? ~externalClockPin : 1'b0;
		end
	end
endmodule : pcm_osc_model
